// file: logic/dpt_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH

// Bus and counter widths
`define DPT_ADDR_W 8
`define DPT_CNT_W 15
`define DPT_CTRL_W 5

// Register byte offsets
`define DPT_OFF_CTRL 8'h00
`define DPT_OFF_PDLY_SET 8'h04
`define DPT_OFF_PDLY_CUR 8'h08
`define DPT_OFF_PLEN_SET 8'h0C
`define DPT_OFF_PLEN_CUR 8'h10
`define DPT_OFF_TDLY_SET 8'h14
`define DPT_OFF_TDLY_CUR 8'h18
`define DPT_OFF_STATUS 8'h1C

// Control fields
`define DPT_CTRL_EDGE 0
`define DPT_CTRL_PTB_LO 1
`define DPT_CTRL_TTB_LO 3
`define DPT_CTRL_RST 5'h00

// Time base codes
`define DPT_TB_10MS 2'h0
`define DPT_TB_100MS 2'h1
`define DPT_TB_1S 2'h2

// Setpoint reset value and limit
`define DPT_SET_RST 15'h0000
`define DPT_SET_MAX 15'h7FFF

// Time base derivation at 200 MHz
`define DPT_CLK_MHZ 200
`define DPT_TB_FAST_US 10000
`define DPT_TB_FAST_CYC (`DPT_TB_FAST_US * `DPT_CLK_MHZ)
`define DPT_TB_DECADE 10

`endif

// file: logic/dpt_pkg.sv
// Types shared by the delayed pulse and toggle timers
`include "dpt_regs.svh"
package dpt_pkg;
   typedef logic [`DPT_CNT_W-1:0] dpt_cnt_t;
   typedef logic [1:0] dpt_tb_t;

   typedef enum logic [1:0] {PST_IDLE, PST_DELAY, PST_PULSE} dpt_pst_e;
   typedef enum logic {TST_IDLE, TST_DELAY} dpt_tst_e;

   typedef struct packed {
      dpt_cnt_t dly_set;
      dpt_cnt_t dly_cur;
      dpt_cnt_t len_set;
      dpt_cnt_t len_cur;
   } dpt_pwords_s;

   typedef struct packed {
      dpt_cnt_t dly_set;
      dpt_cnt_t dly_cur;
   } dpt_twords_s;
endpackage

// file: logic/dpt_tick_gen.sv
// Time base generator: 10 ms, 100 ms and 1 s tick enables
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module dpt_tick_gen #(
   parameter int unsigned FAST_CYC = `DPT_TB_FAST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick_fast,
   output logic tick_mid,
   output logic tick_slow
);
   logic [31:0] cnt_r;
   logic [3:0] dec_mid_r;
   logic [3:0] dec_slow_r;

   // Decode of each wrap point
   wire wrap = (cnt_r == FAST_CYC - 1);
   wire mid_end = (dec_mid_r == 4'(`DPT_TB_DECADE - 1));
   wire slow_end = (dec_slow_r == 4'(`DPT_TB_DECADE - 1));

   // Base divider and two decade stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 32'h00000000;
         dec_mid_r <= 4'h0;
         dec_slow_r <= 4'h0;
      end else begin
         cnt_r <= wrap ? 32'h00000000 : cnt_r + 32'h00000001;
         if (wrap) begin
            dec_mid_r <= mid_end ? 4'h0 : dec_mid_r + 4'h1;
            if (mid_end) begin
               dec_slow_r <= slow_end ? 4'h0 : dec_slow_r + 4'h1;
            end
         end
      end
   end

   // Tick pulses, nested so slower ticks align with faster ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_fast <= 1'b0;
         tick_mid <= 1'b0;
         tick_slow <= 1'b0;
      end else begin
         tick_fast <= wrap;
         tick_mid <= wrap & mid_end;
         tick_slow <= wrap & mid_end & slow_end;
      end
   end

   property p_tick_nest;
      @(posedge pclk) disable iff (!presetn)
      tick_slow |-> tick_mid && tick_fast;
   endproperty
   a_tick_nest: assert property (p_tick_nest)
      else $error("slow tick not aligned with faster ticks");
endmodule
`default_nettype wire

// file: logic/dpt_elapsed.sv
// Elapsed time counter stepped by a time base tick
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module dpt_elapsed #(
   parameter int unsigned W = `DPT_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] setp,
   output logic [W-1:0] cur,
   output logic done
);
   // Interval complete once the count reaches the setpoint
   assign done = (cur >= setp);

   // Count one per tick while running, hold when complete
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else if (clr) begin
         cur <= '0;
      end else if (run && tick && !done) begin
         cur <= W'(cur + 1'b1);
      end
   end

   property p_cnt_step;
      @(posedge pclk) disable iff (!presetn)
      (!clr && run && tick && !done) |=> cur == W'($past(cur) + 1'b1);
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("elapsed count did not step on tick");

   property p_cnt_hold;
      @(posedge pclk) disable iff (!presetn)
      (!clr && !(run && tick)) |=> cur == $past(cur);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("elapsed count moved without a tick");
endmodule
`default_nettype wire

// file: logic/dpt_timers.sv
// Delayed pulse and delayed toggle timers with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"

// How it works
// - The pulse block starts its delay on the rising or falling input edge per the edge setting.
// - In rising mode it waits the delay, then drives its output for the pulse time.
// - In falling mode the output stays on after the input falls until the delay ends.
// - Delay setpoints of both blocks hold counts from 0 to 32767.
// - The pulse time setpoint holds counts from 0 to 32767.
// - Each block picks a 10 ms, 100 ms or 1 s time base.
// - Pulse clear zeroes both elapsed counts and forces the output off.
// - The pulse block shows delay set, delay elapsed, pulse set and pulse elapsed.
// - The toggle block starts its delay on a rising input edge.
// - When the toggle delay ends the toggle output inverts.
// - Toggle clear zeroes the elapsed delay and forces the output off.
// - The toggle block shows its delay set and elapsed delay.
module dpt_timers import dpt_pkg::*; #(
   parameter int unsigned TB_FAST_CYC = `DPT_TB_FAST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DPT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pulse_in,
   input wire logic pulse_clr,
   input wire logic tog_in,
   input wire logic tog_clr,
   output logic pulse_out,
   output logic tog_out,
   output dpt_pwords_s pulse_words,
   output dpt_twords_s tog_words
);
   logic [`DPT_CTRL_W-1:0] ctrl_r;
   dpt_cnt_t pdly_set_r;
   dpt_cnt_t plen_set_r;
   dpt_cnt_t tdly_set_r;
   dpt_cnt_t pdly_cur;
   dpt_cnt_t plen_cur;
   dpt_cnt_t tdly_cur;
   logic pdly_done;
   logic plen_done;
   logic tdly_done;
   logic tk_fast;
   logic tk_mid;
   logic tk_slow;
   logic pin_q_r;
   logic tin_q_r;
   dpt_pst_e pst_r;
   dpt_pst_e pst_nxt;
   dpt_tst_e tst_r;
   dpt_tst_e tst_nxt;
   logic pout_nxt;
   logic tout_nxt;
   logic pstart;
   logic tstart;
   logic [31:0] rd_word;

   // Control field decode
   wire edge_sel_down = ctrl_r[`DPT_CTRL_EDGE];
   wire edge_sel_up = !edge_sel_down;
   wire dpt_tb_t ptb = ctrl_r[`DPT_CTRL_PTB_LO +: 2];
   wire dpt_tb_t ttb = ctrl_r[`DPT_CTRL_TTB_LO +: 2];

   // Time base selection per block
   wire ptick = (ptb == `DPT_TB_10MS) ? tk_fast :
                (ptb == `DPT_TB_100MS) ? tk_mid : tk_slow;
   wire ttick = (ttb == `DPT_TB_10MS) ? tk_fast :
                (ttb == `DPT_TB_100MS) ? tk_mid : tk_slow;

   // Input edge detection
   wire prise = pulse_in & !pin_q_r;
   wire pfall = !pulse_in & pin_q_r;
   wire trise = tog_in & !tin_q_r;

   // APB address decode
   wire sel_ctrl = (paddr == `DPT_OFF_CTRL);
   wire sel_pdly_set = (paddr == `DPT_OFF_PDLY_SET);
   wire sel_pdly_cur = (paddr == `DPT_OFF_PDLY_CUR);
   wire sel_plen_set = (paddr == `DPT_OFF_PLEN_SET);
   wire sel_plen_cur = (paddr == `DPT_OFF_PLEN_CUR);
   wire sel_tdly_set = (paddr == `DPT_OFF_TDLY_SET);
   wire sel_tdly_cur = (paddr == `DPT_OFF_TDLY_CUR);
   wire sel_status = (paddr == `DPT_OFF_STATUS);
   wire hit = sel_ctrl | sel_pdly_set | sel_pdly_cur | sel_plen_set |
              sel_plen_cur | sel_tdly_set | sel_tdly_cur | sel_status;
   wire setup = psel & !penable;
   wire wr_en = psel & penable & pready & pwrite & hit;
   wire [3:0] status = {tst_r == TST_DELAY, pst_r != PST_IDLE,
                        tog_out, pulse_out};

   // Read data selection
   assign rd_word = sel_ctrl ? 32'(ctrl_r) :
                    sel_pdly_set ? 32'(pdly_set_r) :
                    sel_pdly_cur ? 32'(pdly_cur) :
                    sel_plen_set ? 32'(plen_set_r) :
                    sel_plen_cur ? 32'(plen_cur) :
                    sel_tdly_set ? 32'(tdly_set_r) :
                    sel_tdly_cur ? 32'(tdly_cur) :
                    sel_status ? 32'(status) : 32'h00000000;

   // Word values to downstream logic
   assign pulse_words.dly_set = pdly_set_r;
   assign pulse_words.dly_cur = pdly_cur;
   assign pulse_words.len_set = plen_set_r;
   assign pulse_words.len_cur = plen_cur;
   assign tog_words.dly_set = tdly_set_r;
   assign tog_words.dly_cur = tdly_cur;

   // APB answer: zero wait, registered at the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= (setup & !pwrite) ? rd_word : 32'h00000000;
         pslverr <= setup & !hit;
      end
   end

   // Writable registers, setpoints limited to 15 bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `DPT_CTRL_RST;
         pdly_set_r <= `DPT_SET_RST;
         plen_set_r <= `DPT_SET_RST;
         tdly_set_r <= `DPT_SET_RST;
      end else if (wr_en) begin
         if (sel_ctrl) ctrl_r <= pwdata[`DPT_CTRL_W-1:0];
         if (sel_pdly_set) pdly_set_r <= pwdata[`DPT_CNT_W-1:0];
         if (sel_plen_set) plen_set_r <= pwdata[`DPT_CNT_W-1:0];
         if (sel_tdly_set) tdly_set_r <= pwdata[`DPT_CNT_W-1:0];
      end
   end

   // Pulse block sequencing
   always_comb begin
      pst_nxt = pst_r;
      pout_nxt = pulse_out;
      pstart = 1'b0;
      if (pulse_clr) begin
         pst_nxt = PST_IDLE;
         pout_nxt = 1'b0;
      end else begin
         case (pst_r)
            PST_IDLE: begin
               if (edge_sel_down) begin
                  pout_nxt = pulse_in;
                  if (pfall) begin
                     pst_nxt = PST_DELAY;
                     pout_nxt = 1'b1;
                     pstart = 1'b1;
                  end
               end else begin
                  pout_nxt = 1'b0;
                  if (prise) begin
                     pst_nxt = PST_DELAY;
                     pstart = 1'b1;
                  end
               end
            end
            PST_DELAY: begin
               if (edge_sel_down && prise) begin
                  pst_nxt = PST_IDLE;
                  pout_nxt = 1'b1;
               end else if (pdly_done) begin
                  pst_nxt = edge_sel_up ? PST_PULSE : PST_IDLE;
                  pout_nxt = edge_sel_up;
               end
            end
            PST_PULSE: begin
               if (plen_done) begin
                  pst_nxt = PST_IDLE;
                  pout_nxt = 1'b0;
               end
            end
            default: begin
               pst_nxt = PST_IDLE;
               pout_nxt = 1'b0;
            end
         endcase
      end
   end

   // Toggle block sequencing
   always_comb begin
      tst_nxt = tst_r;
      tout_nxt = tog_out;
      tstart = 1'b0;
      if (tog_clr) begin
         tst_nxt = TST_IDLE;
         tout_nxt = 1'b0;
      end else begin
         case (tst_r)
            TST_IDLE: begin
               if (trise) begin
                  tst_nxt = TST_DELAY;
                  tstart = 1'b1;
               end
            end
            TST_DELAY: begin
               if (tdly_done) begin
                  tst_nxt = TST_IDLE;
                  tout_nxt = !tog_out;
               end
            end
            default: begin
               tst_nxt = TST_IDLE;
               tout_nxt = 1'b0;
            end
         endcase
      end
   end

   // State and output flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pst_r <= PST_IDLE;
         tst_r <= TST_IDLE;
         pulse_out <= 1'b0;
         tog_out <= 1'b0;
         pin_q_r <= 1'b0;
         tin_q_r <= 1'b0;
      end else begin
         pst_r <= pst_nxt;
         tst_r <= tst_nxt;
         pulse_out <= pout_nxt;
         tog_out <= tout_nxt;
         pin_q_r <= pulse_in;
         tin_q_r <= tog_in;
      end
   end

   dpt_tick_gen #(
      .FAST_CYC(TB_FAST_CYC)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick_fast(tk_fast),
      .tick_mid(tk_mid),
      .tick_slow(tk_slow)
   );

   // Elapsed counters; clear input and a new start zero them
   dpt_elapsed u_pdly (
      .pclk(pclk),
      .presetn(presetn),
      .clr(pulse_clr | pstart),
      .run(pst_r == PST_DELAY),
      .tick(ptick),
      .setp(pdly_set_r),
      .cur(pdly_cur),
      .done(pdly_done)
   );

   dpt_elapsed u_plen (
      .pclk(pclk),
      .presetn(presetn),
      .clr(pulse_clr | pstart),
      .run(pst_r == PST_PULSE),
      .tick(ptick),
      .setp(plen_set_r),
      .cur(plen_cur),
      .done(plen_done)
   );

   dpt_elapsed u_tdly (
      .pclk(pclk),
      .presetn(presetn),
      .clr(tog_clr | tstart),
      .run(tst_r == TST_DELAY),
      .tick(ttick),
      .setp(tdly_set_r),
      .cur(tdly_cur),
      .done(tdly_done)
   );

   property p_pclr;
      @(posedge pclk) disable iff (!presetn)
      pulse_clr |=> !pulse_out && pdly_cur == '0 && plen_cur == '0;
   endproperty
   a_pclr: assert property (p_pclr)
      else $error("pulse clear left output or counts set");

   property p_up_start;
      @(posedge pclk) disable iff (!presetn)
      (edge_sel_up && pst_r == PST_IDLE && prise && !pulse_clr)
         |=> pst_r == PST_DELAY && !pulse_out && pdly_cur == '0;
   endproperty
   a_up_start: assert property (p_up_start)
      else $error("rising edge did not start the delay");

   property p_pulse_on;
      @(posedge pclk) disable iff (!presetn)
      (edge_sel_up && pst_r == PST_DELAY && pdly_done && !pulse_clr)
         |=> pulse_out && pst_r == PST_PULSE && plen_cur == '0;
   endproperty
   a_pulse_on: assert property (p_pulse_on)
      else $error("pulse did not start when delay ended");

   property p_pulse_off;
      @(posedge pclk) disable iff (!presetn)
      (pst_r == PST_PULSE && plen_done && !pulse_clr) |=> !pulse_out;
   endproperty
   a_pulse_off: assert property (p_pulse_off)
      else $error("pulse did not end at its setpoint");

   property p_down_hold;
      @(posedge pclk) disable iff (!presetn)
      (edge_sel_down && pst_r == PST_DELAY && !pdly_done && !pulse_clr)
         |=> pulse_out;
   endproperty
   a_down_hold: assert property (p_down_hold)
      else $error("output dropped before the off delay ended");

   property p_tclr;
      @(posedge pclk) disable iff (!presetn)
      tog_clr |=> !tog_out && tdly_cur == '0 && tst_r == TST_IDLE;
   endproperty
   a_tclr: assert property (p_tclr)
      else $error("toggle clear left output or count set");

   property p_tstart;
      @(posedge pclk) disable iff (!presetn)
      (tst_r == TST_IDLE && trise && !tog_clr)
         |=> tst_r == TST_DELAY && tdly_cur == '0 && $stable(tog_out);
   endproperty
   a_tstart: assert property (p_tstart)
      else $error("rising edge did not start the toggle delay");

   property p_tflip;
      @(posedge pclk) disable iff (!presetn)
      (tst_r == TST_DELAY && tdly_done && !tog_clr)
         |=> tog_out != $past(tog_out);
   endproperty
   a_tflip: assert property (p_tflip)
      else $error("toggle output did not invert after delay");
endmodule
`default_nettype wire

// file: verification/dpt_fb_model.sv
// Upstream function block logic that drives the timer input and clear pins
`timescale 1ns/1ps
`default_nettype none
module dpt_fb_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] cmd,
   output logic pulse_in,
   output logic pulse_clr,
   output logic tog_in,
   output logic tog_clr
);
   // Pins change once per scan, just after the clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tog_clr, tog_in, pulse_clr, pulse_in} <= 4'h0;
      end else begin
         {tog_clr, tog_in, pulse_clr, pulse_in} <= cmd;
      end
   end
endmodule
`default_nettype wire

// file: verification/delayed_pulse_toggle_timers_bench.sv
// Self-checking bench for the delayed pulse and toggle timers
`timescale 1ns/1ps
`default_nettype none
module delayed_pulse_toggle_timers_bench import dpt_pkg::*;;
   localparam int FC = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, tq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] cmd;
   logic pulse_in, pulse_clr, tog_in, tog_clr, pulse_out, tog_out;
   dpt_pwords_s pulse_words;
   dpt_twords_s tog_words;
   int err_total, cmp_count, n, p;

   // Block under test with a short fast time base
   dpt_timers #(.TB_FAST_CYC(FC)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_in(pulse_in), .pulse_clr(pulse_clr),
      .tog_in(tog_in), .tog_clr(tog_clr), .pulse_out(pulse_out),
      .tog_out(tog_out), .pulse_words(pulse_words), .tog_words(tog_words));

   // Partner driving the input and clear pins
   dpt_fb_model u_fb (.pclk(pclk), .presetn(presetn), .cmd(cmd),
      .pulse_in(pulse_in), .pulse_clr(pulse_clr), .tog_in(tog_in),
      .tog_clr(tog_clr));

   // Clock at 200 MHz
   initial begin
      pclk = 1'b0;
      forever begin
         #2.5 pclk = ~pclk;
      end
   end

   // Verdict and end of run
   task stop_test;
      $display("Checks %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Value comparison
   task chk_val(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Cycle count comparison
   task chk_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("[ERR] %0t %0d cycles outside %0d..%0d", $time, got, lo,
            hi);
      end
   endtask

   // One APB transfer, held until pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read and compare data and error flag
   task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk_val(64'(q), 64'(x));
      chk_val(64'(e), 64'(xe));
   endtask

   // Count edges until an output reaches a level
   task wait_on(input logic t, input logic lvl);
      n = 0;
      while ((t ? tog_out : pulse_out) !== lvl && n < 5000) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task steps(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge pclk);
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   // Test sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cmd = 4'h0;
      tq = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         rd_chk(8'(4 * i), 32'h0, 1'b0);
      end
      rd_chk(8'h20, 32'h0, 1'b1);
      rd_chk(8'h02, 32'h0, 1'b1);
      apb(1'b1, 8'h08, 32'h5);
      rd_chk(8'h08, 32'h0, 1'b0);
      apb(1'b1, 8'h04, 32'hFFFF);
      rd_chk(8'h04, 32'h7FFF, 1'b0);
      apb(1'b1, 8'h0C, 32'hFFFF);
      rd_chk(8'h0C, 32'h7FFF, 1'b0);
      apb(1'b1, 8'h14, 32'h0);
      rd_chk(8'h14, 32'h0, 1'b0);
      $display("Test registers done");
      for (int tb = 0; tb < 3; tb++) begin
         p = FC * (10 ** tb);
         apb(1'b1, 8'h00, 32'(tb * 10));
         apb(1'b1, 8'h04, 32'h2);
         apb(1'b1, 8'h0C, 32'h3);
         apb(1'b1, 8'h14, 32'h2);
         cmd <= 4'h1;
         wait_on(1'b0, 1'b1);
         chk_rng(n, p + 1, 2 * p + 4);
         wait_on(1'b0, 1'b0);
         chk_rng(n, 3 * p - 3, 4 * p + 1);
         chk_val(64'(pulse_words), 64'({15'h0002, 15'h0002, 15'h0003,
            15'h0003}));
         cmd <= 4'h4;
         wait_on(1'b1, !tq);
         chk_rng(n, p + 1, 2 * p + 4);
         tq = !tq;
         chk_val(64'(tog_words), 64'({15'h0002, 15'h0002}));
         cmd <= 4'h0;
         @(posedge pclk);
      end
      $display("Test time bases done");
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h14, 32'h5);
      cmd <= 4'h4;
      steps(12);
      chk_rng(int'(tog_words.dly_cur), 2, 3);
      rd_chk(8'h1C, 32'hA, 1'b0);
      cmd <= 4'hC;
      steps(3);
      chk_val(64'(tog_out), 64'h0);
      chk_val(64'(tog_words.dly_cur), 64'h0);
      apb(1'b1, 8'h14, 32'h0);
      cmd <= 4'h0;
      steps(2);
      cmd <= 4'h4;
      wait_on(1'b1, 1'b1);
      chk_rng(n, 1, 6);
      $display("Test toggle clear done");
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h3);
      cmd <= 4'h1;
      steps(4);
      chk_val(64'(pulse_out), 64'h1);
      cmd <= 4'h0;
      wait_on(1'b0, 1'b0);
      chk_rng(n, 2 * FC + 1, 3 * FC + 4);
      apb(1'b1, 8'h00, 32'h1E);
      cmd <= 4'h1;
      wait_on(1'b0, 1'b1);
      chk_rng(n, 200 * FC + 5, 300 * FC + 4);
      steps(FC);
      cmd <= 4'h3;
      steps(3);
      chk_val(64'(pulse_out), 64'h0);
      chk_val(64'({pulse_words.dly_cur, pulse_words.len_cur}),
         64'h0);
      cmd <= 4'h0;
      $display("Test pulse modes done");
      stop_test();
   end
endmodule
`default_nettype wire
